/* File: encs_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "encs_defines.svh"
module encs_top #(
  parameter int unsigned FAN_TIMEOUT_CYC = `ENCS_FAN_TIMEOUT_S * `ENCS_CLK_HZ
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [31:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [3:0] I_WB_SEL,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_IRQ,
  input wire logic [10:0] I_DIG_IN,
  input wire encs_pkg::encs_enc_t I_ENC1,
  input wire encs_pkg::encs_enc_t I_ENC2,
  output logic O_FAULT_RESET,
  output logic O_EXT_FAN_FAULT,
  output logic O_ALIGN_DONE
);
  logic [31:0] cfg;
  logic [31:0] cmd;
  encs_pkg::encs_pos_t pre [2];
  encs_pkg::encs_pos_t pos [2];
  logic [`ENCS_IRQ_W-1:0] irq_stat;
  logic [`ENCS_IRQ_W-1:0] irq_mask;
  logic [`ENCS_IRQ_W-1:0] irq_ev;
  logic align_done;
  logic fan_fault;
  logic [15:0] pcw;
  logic [15:0] scw;
  logic [15:0] ssw;
  logic [15:0] fw2;

  assign pcw = cmd[`ENCS_F_LO];
  assign scw = cmd[`ENCS_F_HI];

  // Pin sampling: eleven inputs then A, B, Z of both encoders.
  logic [16:0] pin_lvl;
  logic [16:0] pin_rise;
  logic [16:0] pin_fall;

  encs_sync_edge #(.W(17)) u_pins (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_pin({I_ENC2, I_ENC1, I_DIG_IN}),
    .o_level(pin_lvl),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  logic [10:0] di;
  logic d7;
  logic d7_rise;
  logic d7_fall;
  encs_pkg::encs_enc_t enc_lvl [2];
  encs_pkg::encs_enc_t enc_rise [2];

  assign di = pin_lvl[10:0];
  assign d7 = di[`ENCS_DI_SEVEN];
  assign d7_rise = pin_rise[`ENCS_DI_SEVEN];
  assign d7_fall = pin_fall[`ENCS_DI_SEVEN];
  assign enc_lvl[0] = pin_lvl[13:11];
  assign enc_lvl[1] = pin_lvl[16:14];
  assign enc_rise[0] = pin_rise[13:11];
  assign enc_rise[1] = pin_rise[16:14];

  // Returns the level of the binary source chosen by a selector code.
  function automatic logic pick_src(input logic [4:0] code, input logic [10:0] din,
                                    input logic ext, input logic [15:0] pw, input logic [15:0] sw);
    logic [4:0] idx;
    idx = code - `ENCS_SRC_DI_FIRST;
    pick_src = 1'b0;
    if (code >= `ENCS_SRC_DI_FIRST && code <= `ENCS_SRC_DI_LAST) begin
      if (code < `ENCS_SRC_EXT_FIRST || ext) begin // RULE_02
        pick_src = din[idx[3:0]];
      end
    end else if (code >= `ENCS_SRC_PCW_FIRST && code <= `ENCS_SRC_PCW_LAST) begin
      pick_src = pw[idx[3:0]]; // RULE_03
    end else if (code == `ENCS_SRC_SCW13) begin
      pick_src = sw[`ENCS_SCW_B13]; // RULE_04
    end else if (code == `ENCS_SRC_SCW14) begin
      pick_src = sw[`ENCS_SCW_B14]; // RULE_04
    end else if (code == `ENCS_SRC_SCW15) begin
      pick_src = sw[`ENCS_SCW_B15]; // RULE_04
    end
  endfunction : pick_src

  // Fault reset command.
  logic rst_lvl;
  logic rst_prev;
  logic rst_edge;

  assign rst_lvl = pick_src(cfg[`ENCS_F_RST_SRC], di, cfg[`ENCS_B_EXT], pcw, scw);
  assign rst_edge = rst_lvl & ~rst_prev; // RULE_01 RULE_17

  // Changing the selector while the new source is high gives one edge; that is accepted.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      rst_prev <= 1'b1;
      O_FAULT_RESET <= 1'b0;
    end else begin
      rst_prev <= rst_lvl;
      O_FAULT_RESET <= rst_edge; // RULE_01
    end
  end

  // Alignment request bit edge, taken from the register on this clock.
  logic req_prev;
  logic req_rise;
  logic inhibit;

  assign req_rise = scw[`ENCS_SCW_ALIGN_REQ] & ~req_prev; // RULE_12 RULE_17
  assign inhibit = scw[`ENCS_SCW_INHIBIT];

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      req_prev <= 1'b0;
    end else begin
      req_prev <= scw[`ENCS_SCW_ALIGN_REQ];
    end
  end

  // Per encoder: quadrature count, direction and alignment load.
  logic [1:0] aln_load;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_enc
      logic prev_a;
      logic prev_b;
      logic fwd;
      logic step_fwd;
      logic step_rev;
      logic zr;
      logic ev;
      logic [3:0] sel;

      assign sel = (g == 0) ? cfg[`ENCS_F_ALN1] : cfg[`ENCS_F_ALN2];
      assign zr = enc_rise[g].z;
      assign step_rev = ((enc_lvl[g].a ^ prev_a) & (enc_lvl[g].a ^ enc_lvl[g].b))
                      | ((enc_lvl[g].b ^ prev_b) & ~(enc_lvl[g].a ^ enc_lvl[g].b)); // RULE_13
      assign step_fwd = ((enc_lvl[g].a ^ prev_a) & ~(enc_lvl[g].a ^ enc_lvl[g].b))
                      | ((enc_lvl[g].b ^ prev_b) & (enc_lvl[g].a ^ enc_lvl[g].b)); // RULE_16

      always_comb begin
        case (encs_pkg::encs_aln_t'(sel))
          encs_pkg::ALN_OFF: ev = 1'b0; // RULE_09
          encs_pkg::ALN_D7_RISE: ev = d7_rise; // RULE_09
          encs_pkg::ALN_D7HI_Z: ev = zr & d7; // RULE_10
          encs_pkg::ALN_D7HI_Z_FWD: ev = zr & d7 & fwd; // RULE_10
          encs_pkg::ALN_D7HI_Z_REV: ev = zr & d7 & ~fwd; // RULE_10
          encs_pkg::ALN_D7_FALL: ev = d7_fall; // RULE_09
          encs_pkg::ALN_D7LO_Z: ev = zr & ~d7; // RULE_11
          encs_pkg::ALN_D7LO_Z_FWD: ev = zr & ~d7 & fwd; // RULE_11
          encs_pkg::ALN_D7LO_Z_REV: ev = zr & ~d7 & ~fwd; // RULE_11
          encs_pkg::ALN_Z: ev = zr; // RULE_12
          encs_pkg::ALN_REQ: ev = req_rise; // RULE_12
          default: ev = 1'b0;
        endcase
      end

      assign aln_load[g] = ev & ~inhibit; // RULE_08

      always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
          prev_a <= 1'b0;
          prev_b <= 1'b0;
          fwd <= 1'b1;
        end else begin
          prev_a <= enc_lvl[g].a;
          prev_b <= enc_lvl[g].b;
          if (step_rev) begin
            fwd <= 1'b0; // RULE_13
          end else if (step_fwd) begin
            fwd <= 1'b1; // RULE_16
          end
        end
      end

      // A load in the same cycle as a step wins; the step is lost by design.
      always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
          pos[g] <= '0;
        end else if (aln_load[g]) begin
          pos[g] <= pre[g]; // RULE_05 RULE_06
        end else if (step_fwd) begin
          pos[g] <= pos[g] + 32'h0000_0001;
        end else if (step_rev) begin
          pos[g] <= pos[g] - 32'h0000_0001;
        end
      end
    end
  endgenerate

  // Fan acknowledge supervision.
  encs_pkg::encs_fan_t fan_state;
  logic [27:0] fan_cnt;
  logic fan_ack;
  logic fan_trip;

  assign fan_ack = pick_src(cfg[`ENCS_F_FAN], di, cfg[`ENCS_B_EXT], 16'h0000, 16'h0000);
  assign fan_trip = (fan_state == encs_pkg::FAN_WATCH) && !fan_ack
                    && (fan_cnt == 28'(FAN_TIMEOUT_CYC - 1));

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      fan_state <= encs_pkg::FAN_OFF;
      fan_cnt <= '0;
    end else begin
      case (fan_state)
        encs_pkg::FAN_OFF: begin
          fan_cnt <= '0;
          if (cfg[`ENCS_F_FAN] != `ENCS_SRC_NONE) begin
            fan_state <= encs_pkg::FAN_WATCH;
          end
        end
        encs_pkg::FAN_WATCH: begin
          if (cfg[`ENCS_F_FAN] == `ENCS_SRC_NONE) begin
            fan_state <= encs_pkg::FAN_OFF; // RULE_15
          end else if (fan_ack) begin
            fan_cnt <= '0;
          end else if (fan_trip) begin
            fan_state <= encs_pkg::FAN_TRIP; // RULE_14
          end else begin
            fan_cnt <= fan_cnt + 28'h000_0001;
          end
        end
        encs_pkg::FAN_TRIP: begin
          fan_cnt <= '0;
          if (rst_edge || cfg[`ENCS_F_FAN] == `ENCS_SRC_NONE) begin
            fan_state <= encs_pkg::FAN_OFF;
          end
        end
        default: fan_state <= encs_pkg::FAN_OFF;
      endcase
    end
  end

  // The fault stays until a reset command or fan selector 0; a new trip in that cycle wins.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      fan_fault <= 1'b0;
    end else if (fan_trip) begin
      fan_fault <= 1'b1; // RULE_14
    end else if (rst_edge || cfg[`ENCS_F_FAN] == `ENCS_SRC_NONE) begin
      fan_fault <= 1'b0; // RULE_15
    end
  end

  // Wishbone slave: one wait state, answer in the cycle after the request.
  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  logic [7:0] adr;

  assign wb_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  assign wb_wr = wb_req & I_WB_WE;
  assign wb_rd = wb_req & ~I_WB_WE;
  assign adr = I_WB_ADR[7:0];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction : merge

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      cfg <= '0;
      cmd <= '0;
      pre[0] <= '0;
      pre[1] <= '0;
      irq_mask <= '0;
    end else if (wb_wr) begin
      case (adr)
        `ENCS_ADR_CFG: cfg <= merge(cfg, I_WB_DAT, I_WB_SEL);
        `ENCS_ADR_CMD: cmd <= merge(cmd, I_WB_DAT, I_WB_SEL);
        `ENCS_ADR_PRE1: pre[0] <= merge(pre[0], I_WB_DAT, I_WB_SEL);
        `ENCS_ADR_PRE2: pre[1] <= merge(pre[1], I_WB_DAT, I_WB_SEL);
        `ENCS_ADR_MASK: irq_mask <= I_WB_SEL[0] ? I_WB_DAT[`ENCS_IRQ_W-1:0] : irq_mask;
        default: cfg <= cfg;
      endcase
    end
  end

  logic clr_done;
  assign clr_done = wb_wr && adr == `ENCS_ADR_STAT && I_WB_SEL[0]
                    && I_WB_DAT[`ENCS_SSW_ALIGN_DONE];

  // Software clears the done flag by writing one; a load in that cycle wins.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      align_done <= 1'b0;
    end else if (|aln_load) begin
      align_done <= 1'b1; // RULE_07
    end else if (clr_done) begin
      align_done <= 1'b0;
    end
  end

  always_comb begin
    ssw = '0;
    ssw[`ENCS_SSW_ALIGN_DONE] = align_done;
    fw2 = '0;
    fw2[`ENCS_FW2_FAN] = fan_fault;
    irq_ev = '0;
    irq_ev[`ENCS_IRQ_RST] = rst_edge;
    irq_ev[`ENCS_IRQ_ALN1] = aln_load[0];
    irq_ev[`ENCS_IRQ_ALN2] = aln_load[1];
    irq_ev[`ENCS_IRQ_FAN] = fan_trip;
  end

  // Reading the status clears it; events in the same cycle stay set.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      irq_stat <= '0;
    end else if (wb_rd && adr == `ENCS_ADR_IRQ) begin
      irq_stat <= irq_ev;
    end else begin
      irq_stat <= irq_stat | irq_ev;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= '0;
    end else begin
      O_WB_ACK <= wb_req;
      if (wb_rd) begin
        case (adr)
          `ENCS_ADR_CFG: O_WB_DAT <= cfg;
          `ENCS_ADR_CMD: O_WB_DAT <= cmd;
          `ENCS_ADR_PRE1: O_WB_DAT <= pre[0];
          `ENCS_ADR_PRE2: O_WB_DAT <= pre[1];
          `ENCS_ADR_POS1: O_WB_DAT <= pos[0];
          `ENCS_ADR_POS2: O_WB_DAT <= pos[1];
          `ENCS_ADR_STAT: O_WB_DAT <= {fw2, ssw};
          `ENCS_ADR_IRQ: O_WB_DAT <= {28'h0, irq_stat};
          `ENCS_ADR_MASK: O_WB_DAT <= {28'h0, irq_mask};
          default: O_WB_DAT <= '0;
        endcase
      end else begin
        O_WB_DAT <= '0;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
      O_EXT_FAN_FAULT <= 1'b0;
      O_ALIGN_DONE <= 1'b0;
    end else begin
      O_IRQ <= |(irq_stat & irq_mask);
      O_EXT_FAN_FAULT <= fan_fault;
      O_ALIGN_DONE <= align_done;
    end
  end
endmodule : encs_top
`default_nettype wire

/* File: encs_defines.svh */
// Operation
// RULE_01 - Reset command fires only on a rising edge of the chosen source.
// RULE_02 - Reset codes 1..11 pick inputs 1..11; 9..11 need the extension board.
// RULE_03 - Reset codes 12..16 pick primary command word bits 11..15.
// RULE_04 - Code 17,19,20 pick secondary word bits 13,14,15; code 0 picks none.
// RULE_05 - Encoder two alignment loads its low and high preload words.
// RULE_06 - Encoder one alignment loads its own low and high preload words.
// RULE_07 - Any alignment load sets state word bit 5 in the same cycle.
// RULE_08 - Secondary word bit 10 high blocks alignment loads and done flag.
// RULE_09 - Event code 0 disables; 1 is input seven rising; 5 falling.
// RULE_10 - Codes 2,3,4: zero rising with input seven high; 3 forward, 4 reverse.
// RULE_11 - Codes 6,7,8: zero rising with input seven low; 7 forward, 8 reverse.
// RULE_12 - Code 9 is any zero rising edge; code 10 is secondary bit 9 rising.
// RULE_13 - Channel A leading channel B by a quarter period means reverse.
// RULE_14 - Selected fan acknowledge absent ten seconds trips fan fault bit 6.
// RULE_15 - Fan selector 0 means no supervision and never a fan fault; a trip in the cycle the selector goes to 0 still sets the fault for one cycle.
// RULE_16 - Channel B leading channel A means forward rotation.
// RULE_17 - All edges come from clocked samples compared with the previous one.
`ifndef ENCS_DEFINES_SVH
`define ENCS_DEFINES_SVH
`define ENCS_ADR_CFG 8'h00
`define ENCS_ADR_CMD 8'h04
`define ENCS_ADR_PRE1 8'h08
`define ENCS_ADR_PRE2 8'h0c
`define ENCS_ADR_POS1 8'h10
`define ENCS_ADR_POS2 8'h14
`define ENCS_ADR_STAT 8'h18
`define ENCS_ADR_IRQ 8'h1c
`define ENCS_ADR_MASK 8'h20
`define ENCS_F_RST_SRC 4:0
`define ENCS_F_ALN1 11:8
`define ENCS_F_ALN2 15:12
`define ENCS_F_FAN 20:16
`define ENCS_B_EXT 24
`define ENCS_F_LO 15:0
`define ENCS_F_HI 31:16
`define ENCS_SRC_NONE 5'h00
`define ENCS_SRC_DI_FIRST 5'h01
`define ENCS_SRC_EXT_FIRST 5'h09
`define ENCS_SRC_DI_LAST 5'h0b
`define ENCS_SRC_PCW_FIRST 5'h0c
`define ENCS_SRC_PCW_LAST 5'h10
`define ENCS_SRC_SCW13 5'h11
`define ENCS_SRC_SCW14 5'h13
`define ENCS_SRC_SCW15 5'h14
`define ENCS_SCW_B13 13
`define ENCS_SCW_B14 14
`define ENCS_SCW_B15 15
`define ENCS_SCW_ALIGN_REQ 9
`define ENCS_SCW_INHIBIT 10
`define ENCS_SSW_ALIGN_DONE 5
`define ENCS_FW2_FAN 6
`define ENCS_DI_SEVEN 6
`define ENCS_IRQ_RST 0
`define ENCS_IRQ_ALN1 1
`define ENCS_IRQ_ALN2 2
`define ENCS_IRQ_FAN 3
`define ENCS_IRQ_W 4
`define ENCS_CLK_HZ 20000000
`define ENCS_FAN_TIMEOUT_S 10
`endif

/* File: encs_pkg.sv */
`default_nettype none
package encs_pkg;
  typedef enum logic [3:0] {
    ALN_OFF, ALN_D7_RISE, ALN_D7HI_Z, ALN_D7HI_Z_FWD, ALN_D7HI_Z_REV, ALN_D7_FALL,
    ALN_D7LO_Z, ALN_D7LO_Z_FWD, ALN_D7LO_Z_REV, ALN_Z, ALN_REQ
  } encs_aln_t;
  typedef enum logic [1:0] {FAN_OFF, FAN_WATCH, FAN_TRIP} encs_fan_t;
  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } encs_enc_t;
  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
  } encs_pos_t;
endpackage : encs_pkg
`default_nettype wire

/* File: encs_sync_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module encs_sync_edge #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);
  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] prev;

  // The first stage feeds only the second; edges are taken after it.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end else begin
      meta <= i_pin;
      stable <= meta;
      prev <= stable;
    end
  end

  assign o_level = stable;
  assign o_rise = stable & ~prev; // RULE_17
  assign o_fall = ~stable & prev; // RULE_17
endmodule : encs_sync_edge
`default_nettype wire

/* File: encs_enc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module encs_enc_model (
  input wire logic i_clk,
  output var encs_pkg::encs_enc_t o_enc
);
  int ph = 0;
  initial o_enc = '0;
  // Each level is held at least four clocks so the block's two-flop sync never misses a step.
  task automatic step(input bit fwd);
    ph = fwd ? ph + 1 : ph + 3;
    @(posedge i_clk);
    o_enc.a <= ph[1];
    o_enc.b <= ph[1] ^ ph[0];
    repeat (4) @(posedge i_clk);
  endtask : step
  task automatic zpulse();
    @(posedge i_clk);
    o_enc.z <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_enc.z <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask : zpulse
endmodule : encs_enc_model
`default_nettype wire

/* File: encs_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module encs_top_properties #(
  parameter int unsigned FAN_TIMEOUT_CYC = 16
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [31:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic O_IRQ,
  input wire logic [10:0] I_DIG_IN,
  input wire encs_pkg::encs_enc_t I_ENC1,
  input wire encs_pkg::encs_enc_t I_ENC2,
  input wire logic O_FAULT_RESET,
  input wire logic O_EXT_FAN_FAULT,
  input wire logic O_ALIGN_DONE
);
  logic [31:0] run_cyc;
  logic [3:0] quiet;
  logic [3:0] since_wr;
  logic [16:0] last_in;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  always_ff @(posedge I_CLK_SYS) begin
    // A cleared fault needs a full new timeout, so the count restarts while the fault stands.
    if (!I_RST_N || O_EXT_FAN_FAULT) run_cyc <= '0;
    else if (run_cyc < FAN_TIMEOUT_CYC) run_cyc <= run_cyc + 32'h1;
  end
  // Any pin change or bus cycle restarts the quiet count, so a flag rising in a long quiet spell is spurious.
  always_ff @(posedge I_CLK_SYS) begin
    last_in <= {I_DIG_IN, I_ENC1, I_ENC2};
    if (!I_RST_N || I_WB_CYC || last_in != {I_DIG_IN, I_ENC1, I_ENC2}) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N || (I_WB_CYC && I_WB_WE)) since_wr <= 4'h0;
    else if (since_wr != 4'hf) since_wr <= since_wr + 4'h1;
  end
  sequence s_req;
    I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence
  sequence s_still;
    ($stable(I_DIG_IN) && !I_WB_CYC) [*8];
  endsequence
  property p_ack_after_req; s_req |=> O_WB_ACK; endproperty
  a_ack_after_req: assert property (p_ack_after_req) else $error("ack missing after request");
  property p_ack_single; O_WB_ACK |=> !O_WB_ACK; endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");
  property p_ack_cause; O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !O_WB_ACK |-> O_WB_DAT == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_rst_pulse; O_FAULT_RESET |=> !O_FAULT_RESET; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset command longer than a pulse");
  property p_rst_static; s_still |=> !O_FAULT_RESET; endproperty
  a_rst_static: assert property (p_rst_static) else $error("reset command on static level");
  property p_fan_time; $rose(O_EXT_FAN_FAULT) |-> run_cyc >= FAN_TIMEOUT_CYC; endproperty
  a_fan_time: assert property (p_fan_time) else $error("fan fault before timeout");
  property p_done_cause; $rose(O_ALIGN_DONE) |-> quiet < 4'h8; endproperty
  a_done_cause: assert property (p_done_cause) else $error("align done without event");
  property p_done_clear; $fell(O_ALIGN_DONE) |-> since_wr < 4'h4; endproperty
  a_done_clear: assert property (p_done_clear) else $error("align done dropped by itself");
endmodule : encs_top_properties
bind encs_top encs_top_properties #(.FAN_TIMEOUT_CYC(FAN_TIMEOUT_CYC)) u_props (.I_CLK_SYS(I_CLK_SYS),
  .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .I_WB_DAT(I_WB_DAT), .I_WB_SEL(I_WB_SEL), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_IRQ(O_IRQ),
  .I_DIG_IN(I_DIG_IN), .I_ENC1(I_ENC1), .I_ENC2(I_ENC2), .O_FAULT_RESET(O_FAULT_RESET),
  .O_EXT_FAN_FAULT(O_EXT_FAN_FAULT), .O_ALIGN_DONE(O_ALIGN_DONE));
`default_nettype wire

/* File: test_encoder_sync_and_command_select.sv */
`timescale 1ns/1ps
`default_nettype none
`include "encs_defines.svh"
module test_encoder_sync_and_command_select;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we_r = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [10:0] din = 11'h0;
  logic [31:0] rdat;
  logic ack, irq, frst, fan, done;
  wire encs_pkg::encs_enc_t enc1;
  wire encs_pkg::encs_enc_t enc2;
  int bad_count = 0;
  int samples_checked = 0;
  int pulses = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  encs_top #(.FAN_TIMEOUT_CYC(16)) u_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we_r), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(4'hf), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .O_IRQ(irq), .I_DIG_IN(din), .I_ENC1(enc1), .I_ENC2(enc2), .O_FAULT_RESET(frst),
    .O_EXT_FAN_FAULT(fan), .O_ALIGN_DONE(done));
  encs_enc_model u_enc1 (.i_clk(clk), .o_enc(enc1));
  encs_enc_model u_enc2 (.i_clk(clk), .o_enc(enc2));
  task automatic test_done();
    $display("Checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // The run is cut short here if a wait never ends.
  always @(posedge clk) begin
    cycles++;
    if (frst === 1'b1) pulses++;
    if (cycles == 40000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we_r} <= {2'b11, w};
    adr <= {24'h0, a};
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we_r} <= 3'b000;
    chk("bus ack delay", 32'h2, 32'(n));
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(what, e, q);
  endtask : rd
  task automatic t_regs();
    rd(`ENCS_ADR_CFG, 32'h0, "cfg reset");
    rd(`ENCS_ADR_MASK, 32'h0, "mask reset");
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h0, "unmapped");
    wr(`ENCS_ADR_PRE1, 32'hdeadbeef);
    rd(`ENCS_ADR_PRE1, 32'hdeadbeef, "preload");
  endtask : t_regs
  task automatic t_reset_src();
    int b;
    int p;
    p = pulses;
    din <= 11'h7ff;
    wr(`ENCS_ADR_CMD, 32'hffffffff);
    repeat (10) @(posedge clk);
    chk("reset none", 32'h0, 32'(pulses - p));
    din <= 11'h0;
    wr(`ENCS_ADR_CMD, 32'h0);
    for (int c = 1; c <= 20; c++) begin
      wr(`ENCS_ADR_CFG, (c == 9 ? 32'h0 : 32'h01000000) | 32'(c));
      repeat (8) @(posedge clk);
      p = pulses;
      b = (c <= 16) ? c - 1 : (c == 17) ? 29 : (c == 19) ? 30 : 31;
      if (c <= 11) din[c-1] <= 1'b1;
      else wr(`ENCS_ADR_CMD, 32'h1 << b);
      repeat (10) @(posedge clk);
      chk("reset edge", (c == 9 || c == 18) ? 32'h0 : 32'h1, 32'(pulses - p));
      repeat (20) @(posedge clk);
      chk("reset static", (c == 9 || c == 18) ? 32'h0 : 32'h1, 32'(pulses - p));
      din <= 11'h0;
      wr(`ENCS_ADR_CMD, 32'h0);
    end
    wr(`ENCS_ADR_CFG, 32'hc);
    wr(`ENCS_ADR_MASK, 32'h1);
    rd(`ENCS_ADR_IRQ, 32'h1, "irq stale");
    repeat (3) @(posedge clk);
    chk("irq idle", 32'h0, 32'(irq));
    wr(`ENCS_ADR_CMD, 32'h800);
    repeat (6) @(posedge clk);
    chk("irq raised", 32'h1, 32'(irq));
    rd(`ENCS_ADR_IRQ, 32'h1, "irq status");
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    wr(`ENCS_ADR_MASK, 32'h0);
    wr(`ENCS_ADR_CMD, 32'h0);
    wr(`ENCS_ADR_CMD, 32'h800);
    repeat (6) @(posedge clk);
    chk("irq masked", 32'h0, 32'(irq));
    rd(`ENCS_ADR_IRQ, 32'h1, "irq masked status");
  endtask : t_reset_src
  function automatic bit hit(int c, bit d7, bit fwd, int ev);
    case (c)
      1: return ev == 0;
      5: return ev == 1;
      2, 3, 4: return ev == 2 && d7 && (c == 2 || (c == 3) == fwd);
      6, 7, 8: return ev == 2 && !d7 && (c == 6 || (c == 7) == fwd);
      9: return ev == 2;
      10: return ev == 3;
      default: return 1'b0;
    endcase
  endfunction : hit
  task automatic t_align();
    logic [31:0] t;
    bit h;
    t = 32'h0;
    for (int inh = 0; inh < 2; inh++) for (int c = 0; c <= 10; c++) for (int ev = 0; ev < 4; ev++)
      for (int m = 0; m < 4; m++) begin
        if (ev != 2 && m != 0) continue;
        t++;
        wr(`ENCS_ADR_CFG, 32'h0);
        wr(`ENCS_ADR_CMD, 32'(inh) << 26);
        din[6] <= (ev == 0) ? 1'b0 : (ev == 1) ? 1'b1 : m[1];
        repeat (2) fork u_enc1.step(m[0]); u_enc2.step(m[0]); join
        wr(`ENCS_ADR_PRE1, 32'h12340000 + t);
        wr(`ENCS_ADR_PRE2, 32'h56780000 + t);
        wr(`ENCS_ADR_STAT, 32'h20);
        wr(`ENCS_ADR_CFG, (32'(c) << 8) | (32'(c) << 12));
        repeat (4) @(posedge clk);
        case (ev)
          0: din[6] <= 1'b1;
          1: din[6] <= 1'b0;
          2: fork u_enc1.zpulse(); u_enc2.zpulse(); join
          default: wr(`ENCS_ADR_CMD, (32'(inh) << 26) | 32'h02000000);
        endcase
        repeat (10) @(posedge clk);
        h = (inh == 0) && hit(c, m[1], m[0], ev);
        chk("align done", 32'(h), 32'(done));
        if (h) begin
          rd(`ENCS_ADR_POS1, 32'h12340000 + t, "enc1 position");
          rd(`ENCS_ADR_POS2, 32'h56780000 + t, "enc2 position");
        end
      end
  endtask : t_align
  task automatic t_fan();
    din <= 11'h002;
    wr(`ENCS_ADR_CMD, 32'h0);
    wr(`ENCS_ADR_CFG, 32'h00020000);
    repeat (60) @(posedge clk);
    chk("fan ack present", 32'h0, 32'(fan));
    din[1] <= 1'b0;
    repeat (12) @(posedge clk);
    din[1] <= 1'b1;
    repeat (40) @(posedge clk);
    chk("fan short absence", 32'h0, 32'(fan));
    din[1] <= 1'b0;
    repeat (30) @(posedge clk);
    chk("fan trip", 32'h1, 32'(fan));
    rd(`ENCS_ADR_STAT, 32'h00400000, "fault word");
    wr(`ENCS_ADR_CFG, 32'h0);
    repeat (60) @(posedge clk);
    chk("fan unsupervised", 32'h0, 32'(fan));
  endtask : t_fan
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_reset_src();
    t_align();
    t_fan();
    test_done();
  end
endmodule : test_encoder_sync_and_command_select
`default_nettype wire
